//--- logic/pis_pkg.sv
// Purpose: Shared constants for the PCI interrupt steering block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Each register has an index; its byte address is four times that
package pis_pkg;
    localparam int unsigned NUM_PIRQ = 4;
    localparam int unsigned NUM_IRQ = 16;
    localparam logic [6:0] IDX_STEER0 = 7'h60;
    localparam logic [6:0] IDX_STEER1 = 7'h61;
    localparam logic [6:0] IDX_STEER2 = 7'h62;
    localparam logic [6:0] IDX_STEER3 = 7'h63;
    localparam logic [6:0] IDX_PAC = 7'h70;
    localparam logic [6:0] IDX_RELOC = 7'h71;
    localparam logic [6:0] IDX_STATUS = 7'h72;
    localparam logic [6:0] IDX_MASK = 7'h73;
    localparam logic [8:0] OFF_STEER0 = {IDX_STEER0, 2'h0};
    localparam logic [8:0] OFF_STEER1 = {IDX_STEER1, 2'h0};
    localparam logic [8:0] OFF_STEER2 = {IDX_STEER2, 2'h0};
    localparam logic [8:0] OFF_STEER3 = {IDX_STEER3, 2'h0};
    localparam logic [8:0] OFF_PAC = {IDX_PAC, 2'h0};
    localparam logic [8:0] OFF_RELOC = {IDX_RELOC, 2'h0};
    localparam logic [8:0] OFF_STATUS = {IDX_STATUS, 2'h0};
    localparam logic [8:0] OFF_MASK = {IDX_MASK, 2'h0};
    localparam logic [7:0] STEER_RST = 8'h80;
    localparam logic [7:0] PAC_RST = 8'h00;
    localparam logic [7:0] RELOC_RST = 8'h00;
    localparam logic [7:0] STEER_WMASK = 8'h8F;
    localparam logic [7:0] PAC_WMASK = 8'h03;
    localparam logic [7:0] RELOC_WMASK = 8'h3F;
    localparam int unsigned STEER_DIS_BIT = 7;
    localparam int unsigned PAC_SMI_BIT = 1;
    localparam int unsigned PAC_INTMASK_BIT = 0;
    localparam logic [15:0] APIC_PAGE = 16'hFEC0;
    localparam logic [9:0] APIC_OFF_INDEX = 10'h000;
    localparam logic [9:0] APIC_OFF_DATA = 10'h010;
    localparam logic [15:0] IRQ_VALID = 16'hDEF8;
    localparam int unsigned NUM_EVT = 6;
    localparam int unsigned EVT_SMI = 4;
    localparam int unsigned EVT_APIC_HIT = 5;
endpackage

//--- logic/pis_steer_decode.sv
// Purpose: Decodes one steering register into a one-hot legacy line vector
// Assumes: Synchronous level inputs
// Notes: Reserved codes select nothing
`timescale 1ns/100ps
module pis_steer_decode (
    input wire logic [7:0] steer_in,
    input wire logic pirq_active_in,
    output logic [15:0] irq_vec_out
);
    logic [15:0] onehot;
    always_comb begin
        onehot = 16'h0001 << steer_in[3:0];
        if (!steer_in[pis_pkg::STEER_DIS_BIT] && pirq_active_in) begin
            irq_vec_out = onehot & pis_pkg::IRQ_VALID;
        end else begin
            irq_vec_out = 16'h0000;
        end
    end
endmodule

//--- logic/pis_apic_decode.sv
// Purpose: Compares a host address against the relocated APIC window
// Assumes: Host address is 32-bit, byte addressed
// Notes: Only the index and data locations are claimed
`timescale 1ns/100ps
module pis_apic_decode (
    input wire logic [7:0] reloc_in,
    input wire logic [31:0] haddr_in,
    output logic hit_out
);
    logic page_ok;
    logic win_ok;
    logic off_ok;
    always_comb begin
        page_ok = haddr_in[31:16] == pis_pkg::APIC_PAGE;
        win_ok = (reloc_in[5:2] == haddr_in[15:12]) &&
            (reloc_in[1:0] == haddr_in[11:10]);
        off_ok = (haddr_in[9:0] == pis_pkg::APIC_OFF_INDEX) ||
            (haddr_in[9:0] == pis_pkg::APIC_OFF_DATA);
        hit_out = page_ok && win_ok && off_ok;
    end
endmodule

//--- logic/pis_irq_steer.sv
// Purpose: PCI interrupt steering, SMI/INT routing and APIC window relocation
// Assumes: APB slave, all inputs synchronous to ref_clk_in
// Notes: Routing and relocation registers are write only on the bus
//
// Contract
// - Steering register bits 6 to 4 always read as zero.
// - Target code selects legacy line of same number; reserved codes select none.
// - Bit 7 clear enables routing; reset sets it, routing disabled.
// - Several PCI lines steered to one legacy line are ORed as shared.
// - Configuration register is write only, resets to zero, bits 7:2 reserved.
// - SMI routing bit one sends SMI through APIC, zero to dedicated pin.
// - While SMI goes through APIC, legacy INT is not routed to APIC.
// - INT-mask bit forces INT inactive yet still driven.
// - Relocation register is write only, resets to zero, bits 7:6 reserved.
// - Window hit needs relocation bits 5:2, 1:0 match address 15:12, 11:10.
// - Two locations, offsets 00h and 10h, in a 1 Kbyte aligned window.
// - Reset relocation value places the window at FEC00000h.
`timescale 1ns/100ps
module pis_irq_steer (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [8:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [3:0] pci_irq_lines_n_in,
    input wire logic legacy_int_req_in,
    input wire logic sysmgmt_req_in,
    input wire logic [31:0] host_addr_in,
    input wire logic host_addr_valid_in,
    output logic [15:0] legacy_irq_target_out,
    output logic legacy_int_out,
    output logic legacy_int_oe_out,
    output logic sysmgmt_irq_pin_n_out,
    output logic local_apic_int_input_out,
    output logic apic_decode_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0] steer_q [pis_pkg::NUM_PIRQ];
    logic [7:0] steer_d [pis_pkg::NUM_PIRQ];
    logic [7:0] pic_apic_config_q;
    logic [7:0] pic_apic_config_d;
    logic [7:0] apic_window_relocate_q;
    logic [7:0] apic_window_relocate_d;
    logic [5:0] status_q;
    logic [5:0] status_d;
    logic [5:0] mask_q;
    logic [5:0] mask_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;

    logic setup;
    logic access;
    logic wr_ok;
    logic mapped;
    logic [5:0] events;
    logic [3:0] pirq_prev_q;
    logic [3:0] pirq_prev_d;
    logic apic_hit_prev_q;
    logic apic_hit_prev_d;
    logic smi_prev_q;
    logic smi_prev_d;
    typedef enum logic [1:0] {
        APB_IDLE = 2'h0,
        APB_ACCESS = 2'h1,
        APB_ANSWER = 2'h3,
        APB_RELEASE = 2'h2
    } pis_apb_e;
    pis_apb_e apb_q;
    pis_apb_e apb_d;

    ////////////////////////////////////////////////////////////////////////
    // Steering decode

    logic [15:0] irq_vec [pis_pkg::NUM_PIRQ];
    logic [15:0] irq_or;
    logic apic_hit;

    genvar g;
    generate
        for (g = 0; g < pis_pkg::NUM_PIRQ; g++) begin : g_steer
            pis_steer_decode u_dec (
                .steer_in(steer_q[g]),
                .pirq_active_in(!pci_irq_lines_n_in[g]),
                .irq_vec_out(irq_vec[g])
            );
        end
    endgenerate

    always_comb begin
        irq_or = 16'h0000;
        for (int i = 0; i < pis_pkg::NUM_PIRQ; i++) begin
            irq_or = irq_or | irq_vec[i];
        end
    end

    pis_apic_decode u_apic (
        .reloc_in(apic_window_relocate_q),
        .haddr_in(host_addr_in),
        .hit_out(apic_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB register access

    always_comb begin
        setup = psel_in && !penable_in;
        access = psel_in && penable_in && pready_q;
        mapped = 1'b0;
        case (paddr_in)
            pis_pkg::OFF_STEER0, pis_pkg::OFF_STEER1,
            pis_pkg::OFF_STEER2, pis_pkg::OFF_STEER3,
            pis_pkg::OFF_PAC, pis_pkg::OFF_RELOC,
            pis_pkg::OFF_STATUS, pis_pkg::OFF_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        wr_ok = access && pwrite_in && mapped && pstrb_in[0];
    end

    always_comb begin
        for (int i = 0; i < pis_pkg::NUM_PIRQ; i++) begin
            steer_d[i] = steer_q[i];
        end
        pic_apic_config_d = pic_apic_config_q;
        apic_window_relocate_d = apic_window_relocate_q;
        mask_d = mask_q;
        if (wr_ok) begin
            case (paddr_in)
                pis_pkg::OFF_STEER0: steer_d[0] =
                    pwdata_in[7:0] & pis_pkg::STEER_WMASK;
                pis_pkg::OFF_STEER1: steer_d[1] =
                    pwdata_in[7:0] & pis_pkg::STEER_WMASK;
                pis_pkg::OFF_STEER2: steer_d[2] =
                    pwdata_in[7:0] & pis_pkg::STEER_WMASK;
                pis_pkg::OFF_STEER3: steer_d[3] =
                    pwdata_in[7:0] & pis_pkg::STEER_WMASK;
                pis_pkg::OFF_PAC: pic_apic_config_d =
                    pwdata_in[7:0] & pis_pkg::PAC_WMASK;
                pis_pkg::OFF_RELOC: apic_window_relocate_d =
                    pwdata_in[7:0] & pis_pkg::RELOC_WMASK;
                pis_pkg::OFF_MASK: mask_d = pwdata_in[5:0];
                default: mask_d = mask_q;
            endcase
        end
    end

    // Transfer phase; release also accepts an immediate new setup
    always_comb begin
        apb_d = apb_q;
        case (apb_q)
            APB_IDLE, APB_RELEASE: begin
                apb_d = setup ? APB_ACCESS : APB_IDLE;
            end
            APB_ACCESS: begin
                if (psel_in && penable_in) begin
                    apb_d = APB_ANSWER;
                end else if (!psel_in) begin
                    apb_d = APB_IDLE;
                end
            end
            APB_ANSWER: apb_d = APB_RELEASE;
            default: apb_d = APB_IDLE;
        endcase
    end

    // Answers in the second access cycle: pready low first, then high
    always_comb begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (apb_q == APB_ACCESS && psel_in && penable_in) begin
            pready_d = 1'b1;
            pslverr_d = !mapped;
            if (!pwrite_in) begin
                case (paddr_in)
                    pis_pkg::OFF_STEER0: prdata_d = {24'h000000, steer_q[0]};
                    pis_pkg::OFF_STEER1: prdata_d = {24'h000000, steer_q[1]};
                    pis_pkg::OFF_STEER2: prdata_d = {24'h000000, steer_q[2]};
                    pis_pkg::OFF_STEER3: prdata_d = {24'h000000, steer_q[3]};
                    pis_pkg::OFF_STATUS: prdata_d = {26'h0000000, status_q};
                    pis_pkg::OFF_MASK: prdata_d = {26'h0000000, mask_q};
                    // Write-only registers read as zero
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status

    always_comb begin
        pirq_prev_d = ~pci_irq_lines_n_in;
        apic_hit_prev_d = apic_hit && host_addr_valid_in;
        smi_prev_d = sysmgmt_req_in;
        events[3:0] = pirq_prev_d & ~pirq_prev_q;
        events[pis_pkg::EVT_SMI] = sysmgmt_req_in && !smi_prev_q;
        events[pis_pkg::EVT_APIC_HIT] = apic_hit_prev_d && !apic_hit_prev_q;
        status_d = status_q;
        if (wr_ok && paddr_in == pis_pkg::OFF_STATUS) begin
            status_d = status_q & ~pwdata_in[5:0];
        end
        // Set wins over a same-cycle clear
        status_d = status_d | events;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output routing

    logic [15:0] irq_tgt_d;
    logic int_d;
    logic smi_pin_n_d;
    logic lapic_d;
    logic apic_dec_d;
    logic irq_d;
    logic int_oe_d;

    always_comb begin
        irq_tgt_d = irq_or;
        // Masked INT is held low, still driven
        int_d = legacy_int_req_in &&
            !pic_apic_config_q[pis_pkg::PAC_INTMASK_BIT];
        if (pic_apic_config_q[pis_pkg::PAC_SMI_BIT]) begin
            smi_pin_n_d = 1'b1;
            lapic_d = sysmgmt_req_in;
        end else begin
            smi_pin_n_d = !sysmgmt_req_in;
            lapic_d = legacy_int_req_in;
        end
        apic_dec_d = apic_hit && host_addr_valid_in;
        irq_d = |(status_q & mask_q);
        int_oe_d = 1'b1;
    end

    logic [15:0] irq_tgt_q;
    logic int_q;
    logic smi_pin_n_q;
    logic lapic_q;
    logic apic_dec_q;
    logic irq_q;
    logic int_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // State registers

    // Software registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < pis_pkg::NUM_PIRQ; i++) begin
                steer_q[i] <= pis_pkg::STEER_RST;
            end
            pic_apic_config_q <= pis_pkg::PAC_RST;
            apic_window_relocate_q <= pis_pkg::RELOC_RST;
            mask_q <= 6'h00;
        end else if (clk_en_in) begin
            for (int i = 0; i < pis_pkg::NUM_PIRQ; i++) begin
                steer_q[i] <= steer_d[i];
            end
            pic_apic_config_q <= pic_apic_config_d;
            apic_window_relocate_q <= apic_window_relocate_d;
            mask_q <= mask_d;
        end
    end

    // Bus answer
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            apb_q <= APB_IDLE;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (clk_en_in) begin
            apb_q <= apb_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Event capture
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            status_q <= 6'h00;
            pirq_prev_q <= 4'h0;
            apic_hit_prev_q <= 1'b0;
            smi_prev_q <= 1'b0;
        end else if (clk_en_in) begin
            status_q <= status_d;
            pirq_prev_q <= pirq_prev_d;
            apic_hit_prev_q <= apic_hit_prev_d;
            smi_prev_q <= smi_prev_d;
        end
    end

    // Pin outputs
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            irq_tgt_q <= 16'h0000;
            int_q <= 1'b0;
            smi_pin_n_q <= 1'b1;
            lapic_q <= 1'b0;
            apic_dec_q <= 1'b0;
            irq_q <= 1'b0;
            int_oe_q <= 1'b1;
        end else if (clk_en_in) begin
            irq_tgt_q <= irq_tgt_d;
            int_q <= int_d;
            smi_pin_n_q <= smi_pin_n_d;
            lapic_q <= lapic_d;
            apic_dec_q <= apic_dec_d;
            irq_q <= irq_d;
            int_oe_q <= int_oe_d;
        end
    end

    always_comb begin
        prdata_out = prdata_q;
        pready_out = pready_q;
        pslverr_out = pslverr_q;
        legacy_irq_target_out = irq_tgt_q;
        legacy_int_out = int_q;
        legacy_int_oe_out = int_oe_q;
        sysmgmt_irq_pin_n_out = smi_pin_n_q;
        local_apic_int_input_out = lapic_q;
        apic_decode_out = apic_dec_q;
        irq_out = irq_q;
    end

endmodule

//--- bench/pis_far_end.sv
// Purpose: Far-side model: PCI lines, PIC/SMI requests, host address
// Assumes: Bench sets the wanted levels; model drives them a clock later
// Notes: Host address is scrambled when not qualified
`timescale 1ns/100ps
module pis_far_end (
    input wire logic clk_in,
    input wire logic [3:0] act_in,
    input wire logic int_in,
    input wire logic smi_in,
    input wire logic [31:0] addr_in,
    input wire logic go_in,
    output logic [3:0] pirq_n_out,
    output logic int_req_out,
    output logic smi_req_out,
    output logic [31:0] haddr_out,
    output logic hvalid_out
);
    always_ff @(posedge clk_in) begin
        pirq_n_out <= ~act_in;
        int_req_out <= int_in;
        smi_req_out <= smi_in;
        hvalid_out <= go_in;
        haddr_out <= go_in ? addr_in : ~haddr_out;
    end
endmodule

//--- bench/pis_irq_steer_properties.sv
// Purpose: Port-level checks of the steering block
// Assumes: Clock enable held high
// Notes: Attached by bind
`timescale 1ns/100ps
module pis_irq_steer_checker (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic [3:0] pci_irq_lines_n_in,
    input wire logic legacy_int_req_in,
    input wire logic sysmgmt_req_in,
    input wire logic [31:0] host_addr_in,
    input wire logic host_addr_valid_in,
    input wire logic [15:0] legacy_irq_target_out,
    input wire logic legacy_int_out,
    input wire logic legacy_int_oe_out,
    input wire logic sysmgmt_irq_pin_n_out,
    input wire logic local_apic_int_input_out,
    input wire logic apic_decode_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_rdy_wait;
        psel_in && penable_in && !pready_out |=> pready_out;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("no ready");
    property p_rdy_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
    property p_oe;
        legacy_int_oe_out;
    endproperty
    a_oe: assert property (p_oe) else $error("int undriven");
    property p_int;
        legacy_int_out |-> $past(legacy_int_req_in);
    endproperty
    a_int: assert property (p_int) else $error("int uncaused");
    property p_smi_pin;
        !sysmgmt_irq_pin_n_out |-> $past(sysmgmt_req_in);
    endproperty
    a_smi_pin: assert property (p_smi_pin) else $error("smi pin");
    property p_smi_apic;
        $past(sysmgmt_req_in) && sysmgmt_irq_pin_n_out
            |-> local_apic_int_input_out;
    endproperty
    a_smi_apic: assert property (p_smi_apic) else $error("smi lost");
    property p_lapic;
        local_apic_int_input_out
            |-> $past(legacy_int_req_in) || $past(sysmgmt_req_in);
    endproperty
    a_lapic: assert property (p_lapic) else $error("lapic src");
    property p_dec;
        apic_decode_out |-> $past(host_addr_valid_in)
            && $past(host_addr_in[31:16]) == pis_pkg::APIC_PAGE
            && ($past(host_addr_in[9:0]) inside {10'h000, 10'h010});
    endproperty
    a_dec: assert property (p_dec) else $error("bad hit");
    property p_rsv;
        (legacy_irq_target_out & 16'h2107) == 16'h0000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved irq");
    property p_src;
        |legacy_irq_target_out |-> !(&$past(pci_irq_lines_n_in));
    endproperty
    a_src: assert property (p_src) else $error("irq uncaused");
endmodule
bind pis_irq_steer pis_irq_steer_checker i_chk (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pready_out(pready_out),
    .pci_irq_lines_n_in(pci_irq_lines_n_in),
    .legacy_int_req_in(legacy_int_req_in), .sysmgmt_req_in(sysmgmt_req_in),
    .host_addr_in(host_addr_in), .host_addr_valid_in(host_addr_valid_in),
    .legacy_irq_target_out(legacy_irq_target_out),
    .legacy_int_out(legacy_int_out), .legacy_int_oe_out(legacy_int_oe_out),
    .sysmgmt_irq_pin_n_out(sysmgmt_irq_pin_n_out),
    .local_apic_int_input_out(local_apic_int_input_out),
    .apic_decode_out(apic_decode_out));

//--- bench/testbench.sv
// Purpose: Register-level tests of the steering block
// Assumes: One wait state APB slave
// Notes: Far side driven through its model
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic int_r = 1'b0, smi_r = 1'b0, pready, pslverr, re;
    logic [8:0] paddr = 9'h000;
    logic [31:0] pwdata = 32'h0, addr = 32'h0, prdata, rv, ha;
    logic [3:0] act = 4'h0, pirq_n;
    logic [15:0] tgt;
    logic int_q, smi_q, hv, lint, loe, spin, lapic, dec, irq;
    int failures = 0;
    int cmp_count = 0;
    logic [31:0] at [6] = '{32'hFEC00000, 32'hFEC00010, 32'hFEC00004,
        32'hFEC10000, 32'hFEC0B400, 32'hFEC0B410};
    always #12.5 clk = ~clk;
    pis_far_end i_pis_far_end (.clk_in(clk), .act_in(act), .int_in(int_r),
        .smi_in(smi_r), .addr_in(addr), .go_in(go), .pirq_n_out(pirq_n),
        .int_req_out(int_q), .smi_req_out(smi_q), .haddr_out(ha),
        .hvalid_out(hv));
    pis_irq_steer i_pis_irq_steer (.ref_clk_in(clk), .sys_rst_in(rst),
        .clk_en_in(1'b1), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .pci_irq_lines_n_in(pirq_n),
        .legacy_int_req_in(int_q), .sysmgmt_req_in(smi_q),
        .host_addr_in(ha), .host_addr_valid_in(hv),
        .legacy_irq_target_out(tgt), .legacy_int_out(lint),
        .legacy_int_oe_out(loe), .sysmgmt_irq_pin_n_out(spin),
        .local_apic_int_input_out(lapic), .apic_decode_out(dec),
        .irq_out(irq));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [8:0] a, input int d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= 32'(d);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk iff pready === 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic probe(input logic [31:0] a, input logic e);
        @(posedge clk);
        addr <= a;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        settle(1);
        chk("apic_decode", 32'(dec), 32'(e));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            acc(0, i < 4 ? pis_pkg::OFF_STEER0 + 9'(4 * i)
                : pis_pkg::OFF_PAC + 9'(4 * (i - 4)), 0);
            chk("reset_read", rv, i < 4 ? 32'h80 : 32'h0);
        end
        acc(0, 9'h040, 0);
        chk("unmapped_err", 32'(re), 32'h1);
        acc(1, pis_pkg::OFF_STEER0, 'hFF);
        acc(0, pis_pkg::OFF_STEER0, 0);
        chk("steer_rsv", rv, 32'h8F);
        act <= 4'h1;
        for (int c = 0; c < 16; c++) begin
            acc(1, pis_pkg::OFF_STEER0, c);
            settle(2);
            chk("steer_code", 32'(tgt), (c inside {[3:7], [9:12], 14, 15})
                ? 32'h1 << c : 32'h0);
        end
        acc(1, pis_pkg::OFF_STEER0, 5);
        acc(1, pis_pkg::OFF_STEER1, 5);
        act <= 4'h3;
        settle(2);
        chk("shared", 32'(tgt), 32'h20);
        @(posedge clk);
        act <= 4'h2;
        settle(2);
        chk("shared_one", 32'(tgt), 32'h20);
        acc(1, pis_pkg::OFF_STEER1, 'h85);
        settle(2);
        chk("disabled", 32'(tgt), 32'h0);
        act <= 4'h0;
        for (int c = 0; c < 4; c++) begin
            acc(1, pis_pkg::OFF_PAC, c);
            for (int r = 0; r < 4; r++) begin
                @(posedge clk);
                int_r <= r[0];
                smi_r <= r[1];
                settle(2);
                chk("smi_pin", 32'(spin), 32'(c[1] | !r[1]));
                chk("lapic", 32'(lapic), 32'(c[1] ? r[1] : r[0]));
                chk("int_out", 32'(lint), 32'(r[0] & !c[0]));
                chk("int_oe", 32'(loe), 32'h1);
            end
        end
        int_r <= 1'b0;
        smi_r <= 1'b0;
        acc(0, pis_pkg::OFF_PAC, 0);
        chk("pac_read", rv, 32'h0);
        for (int ph = 0; ph < 2; ph++) begin
            for (int i = 0; i < 6; i++) probe(at[i], ph ? i >= 4 : i < 2);
            acc(1, pis_pkg::OFF_RELOC, 'h2D);
        end
        acc(0, pis_pkg::OFF_RELOC, 0);
        chk("reloc_read", rv, 32'h0);
        acc(1, pis_pkg::OFF_MASK, 0);
        acc(1, pis_pkg::OFF_STATUS, 'h3F);
        act <= 4'h4;
        settle(3);
        acc(0, pis_pkg::OFF_STATUS, 0);
        chk("status", rv, 32'h04);
        settle(1);
        chk("irq_masked", 32'(irq), 32'h0);
        acc(1, pis_pkg::OFF_MASK, 'h04);
        settle(2);
        chk("irq_on", 32'(irq), 32'h1);
        acc(1, pis_pkg::OFF_STATUS, 'h04);
        settle(2);
        chk("irq_off", 32'(irq), 32'h0);
        acc(0, pis_pkg::OFF_STATUS, 0);
        chk("status_clr", rv, 32'h0);
        close_out();
    end
endmodule
